// File: bench/csf_far_end.sv
// Far-side model: external trap pin and hall position sensors
`timescale 1ns/1ps
module csf_far_end (
    input wire logic clk_sys_i,
    input wire logic trap_req_i,
    input wire logic [2:0] hall_req_i,
    output logic trap_input_o,
    output logic [2:0] hall_o
);
    // Pin changes land on the clock edge one cycle after the request, in step with the sampling clock
    always_ff @(posedge clk_sys_i) begin
        trap_input_o <= !trap_req_i;
        hall_o <= hall_req_i;
    end
endmodule // csf_far_end

// File: bench/tb_top.sv
// Self-checking testbench of the upper status flag block
`timescale 1ns/1ps
module tb_top;
    import csf_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [AW-1:0] aw_a = '0, ar_a = '0;
    logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic [31:0] w_d = '0, rd, r_d;
    logic t2cm = 1'b0, t2pm = 1'b0, hedge = 1'b0, tsync = 1'b0, shx = 1'b0, trap_req = 1'b0;
    logic [NHALL-1:0] hall_req = '0, hall;
    logic [NOUT-1:0] shp = '0, pwm = '0, mcp, outs;
    logic trap_n, aw_rdy, w_rdy, b_v, ar_rdy, r_v, irq;
    logic [1:0] b_resp, r_resp, last_resp;
    int num_errors = 0;
    int n_checks = 0;

    always #25 clk_sys_i = ~clk_sys_i;

    csf_far_end PEER (.clk_sys_i(clk_sys_i), .trap_req_i(trap_req), .hall_req_i(hall_req),
        .trap_input_o(trap_n), .hall_o(hall));
    csf_top DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .s_awaddr_i(aw_a),
        .s_awvalid_i(aw_v), .s_awready_o(aw_rdy), .s_wdata_i(w_d), .s_wstrb_i(4'hF),
        .s_wvalid_i(w_v), .s_wready_o(w_rdy), .s_bresp_o(b_resp), .s_bvalid_o(b_v),
        .s_bready_i(b_r), .s_araddr_i(ar_a), .s_arvalid_i(ar_v), .s_arready_o(ar_rdy),
        .s_rdata_o(r_d), .s_rresp_o(r_resp), .s_rvalid_o(r_v), .s_rready_i(r_r),
        .timer2_compare_match_i(t2cm), .timer2_period_match_i(t2pm), .trap_input_i(trap_n),
        .hall_position_inputs_i(hall), .hall_edge_i(hedge), .trap_sync_i(tsync),
        .shadow_transfer_i(shx), .multichannel_shadow_pattern_i(shp), .pwm_outputs_i(pwm),
        .multichannel_pattern_o(mcp), .ccu_outputs_o(outs), .irq_o(irq));

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    // Address and data are offered together and each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (aw_rdy) aw_v <= 1'b0;
            if (w_rdy) w_v <= 1'b0;
        end while (!b_v);
        last_resp = b_resp;
        b_r <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge clk_sys_i);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do begin
            @(posedge clk_sys_i);
            if (ar_rdy) ar_v <= 1'b0;
        end while (!r_v);
        rd = r_d;
        last_resp = r_resp;
        r_r <= 1'b0;
    endtask

    // Only the upper flag byte belongs to this block
    task automatic st(input string nm, input logic [7:0] e);
        rdr(OFS_STATUS);
        chk(nm, {24'h00_0000, e}, {24'h00_0000, rd[15:8]});
    endtask

    task automatic pulse(input int k);
        @(posedge clk_sys_i);
        case (k)
            0: t2cm <= 1'b1;
            1: t2pm <= 1'b1;
            2: hedge <= 1'b1;
            3: tsync <= 1'b1;
            default: shx <= 1'b1;
        endcase
        @(posedge clk_sys_i);
        t2cm <= 1'b0;
        t2pm <= 1'b0;
        hedge <= 1'b0;
        tsync <= 1'b0;
        shx <= 1'b0;
    endtask

    task automatic t_reset();
        st("status_rst", 8'h00);
        rdr(OFS_SET);
        chk("set_reads", 32'h0000_0000, rd);
        chk("irq_rst", 32'h0000_0000, 32'(irq));
        rdr(8'h44);
        chk("rd_unmapped", 32'(RESP_SLVERR), 32'(last_resp));
        wr(8'h44, 32'h0000_FFFF);
        chk("wr_unmapped", 32'(RESP_SLVERR), 32'(last_resp));
        st("unmapped_effect", 8'h00);
    endtask

    task automatic t_timer();
        pulse(0);
        cyc(3);
        st("cmp_sticky", 8'h01);
        pulse(1);
        cyc(3);
        st("per_sticky", 8'h03);
        wr(OFS_RESET, 32'h0000_0000);
        st("reset_zero", 8'h03);
        wr(OFS_RESET, 32'h0000_0100);
        st("reset_one", 8'h02);
        wr(OFS_RESET, 32'h0000_F700);
        st("reset_all", 8'h00);
    endtask

    task automatic t_shadow();
        wr(OFS_CTRL, 32'h0000_0004);
        @(posedge clk_sys_i);
        shp <= 6'h15;
        pulse(4);
        cyc(2);
        chk("mc_copy", 32'h0000_0015, 32'(mcp));
        st("shadow_flag", 8'h80);
    endtask

    task automatic t_hall();
        wr(OFS_HALL, 32'h0000_0031);
        @(posedge clk_sys_i);
        hall_req <= 3'h3;
        cyc(6);
        pulse(2);
        st("hall_ok", 8'h90);
        wr(OFS_HALL, 32'h0000_0023);
        @(posedge clk_sys_i);
        hall_req <= 3'h6;
        cyc(6);
        pulse(2);
        st("hall_wrong", 8'hF0);
        chk("idle_pattern", 32'h0000_0000, 32'(mcp));
        wr(OFS_RESET, 32'h0000_2000);
        st("idle_kept", 8'hD0);
        wr(OFS_RESET, 32'h0000_F700);
        st("hall_clr", 8'h00);
    endtask

    task automatic t_swset();
        wr(OFS_CTRL, 32'h0000_0002);
        wr(OFS_MASK, 32'h0000_00FF);
        rdr(OFS_IRQ_STAT);
        cyc(2);
        chk("irq_idle", 32'h0000_0000, 32'(irq));
        wr(OFS_SET, 32'h0000_0100);
        cyc(2);
        chk("irq_swset", 32'h0000_0001, 32'(irq));
        rdr(OFS_IRQ_STAT);
        chk("irq_stat", 32'h0000_0001, rd);
        cyc(2);
        chk("irq_cleared", 32'h0000_0000, 32'(irq));
        wr(OFS_SET, 32'h0000_0100);
        cyc(2);
        chk("irq_again", 32'h0000_0001, 32'(irq));
        rdr(OFS_IRQ_STAT);
        wr(OFS_SET, 32'h0000_0C00);
        st("sw_trap", 8'h0D);
        wr(OFS_MASK, 32'h0000_0000);
        wr(OFS_SET, 32'h0000_0200);
        cyc(2);
        chk("irq_masked", 32'h0000_0000, 32'(irq));
        rdr(OFS_SET);
        chk("set_reads2", 32'h0000_0000, rd);
        wr(OFS_RESET, 32'h0000_F700);
        st("sw_clr", 8'h00);
    endtask

    task automatic t_trap();
        wr(OFS_PASSIVE, 32'h0000_0F05);
        @(posedge clk_sys_i);
        pwm <= 6'h2A;
        wr(OFS_CTRL, 32'h0000_0009);
        cyc(2);
        chk("out_normal", 32'h0000_002A, 32'(outs));
        trap_req <= 1'b1;
        cyc(8);
        st("trap_set", 8'h0C);
        chk("out_passive", 32'h0000_0025, 32'(outs));
        trap_req <= 1'b0;
        cyc(8);
        st("trap_release", 8'h08);
        pulse(3);
        cyc(3);
        st("trap_synced", 8'h00);
        chk("out_back", 32'h0000_002A, 32'(outs));
        wr(OFS_CTRL, 32'h0000_0003);
        trap_req <= 1'b1;
        cyc(8);
        trap_req <= 1'b0;
        cyc(8);
        st("trap_held", 8'h0C);
        wr(OFS_RESET, 32'h0000_0400);
        st("trap_sw_clr", 8'h00);
        wr(OFS_SET, 32'h0000_4000);
        cyc(2);
        chk("idle_passive", 32'h0000_0025, 32'(outs));
        wr(OFS_RESET, 32'h0000_4000);
        cyc(2);
        chk("idle_left", 32'h0000_002A, 32'(outs));
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_timer();
        t_shadow();
        t_hall();
        t_swset();
        t_trap();
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        num_errors++;
        end_of_test();
    end
endmodule // tb_top

// File: hw/csf_axil.sv
// AXI4-Lite slave front end: accepts one write and one read, hands them on as strobes
`timescale 1ns/1ps
module csf_axil (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [csf_pkg::AW-1:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    input wire logic [csf_pkg::AW-1:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    output logic wr_o,
    output logic [csf_pkg::AW-1:0] wr_addr_o,
    output logic [31:0] wr_data_o,
    output logic [3:0] wr_strb_o,
    input wire logic wr_err_i,
    output logic rd_o,
    output logic [csf_pkg::AW-1:0] rd_addr_o,
    input wire logic [31:0] rd_data_i,
    input wire logic rd_err_i
);
    import csf_pkg::*;
    logic aw_have, w_have, next_aw_have, next_w_have;
    logic [AW-1:0] awaddr, next_awaddr;
    logic [31:0] wdata, next_wdata;
    logic [3:0] wstrb, next_wstrb;
    logic bvalid, next_bvalid, rvalid, next_rvalid;
    logic [1:0] bresp, next_bresp, rresp, next_rresp;
    logic [31:0] rdata, next_rdata;

    assign s_awready_o = !aw_have && !bvalid;
    assign s_wready_o = !w_have && !bvalid;
    assign s_arready_o = !rvalid;
    assign wr_o = aw_have && w_have && !bvalid;
    assign wr_addr_o = awaddr;
    assign wr_data_o = wdata;
    assign wr_strb_o = wstrb;
    assign rd_o = s_arvalid_i && !rvalid;
    assign rd_addr_o = s_araddr_i;
    assign s_bvalid_o = bvalid;
    assign s_bresp_o = bresp;
    assign s_rvalid_o = rvalid;
    assign s_rresp_o = rresp;
    assign s_rdata_o = rdata;

    always_comb begin
        next_aw_have = aw_have;
        next_w_have = w_have;
        next_awaddr = awaddr;
        next_wdata = wdata;
        next_wstrb = wstrb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        if (s_awvalid_i && s_awready_o) begin
            next_aw_have = 1'b1;
            next_awaddr = s_awaddr_i;
        end
        if (s_wvalid_i && s_wready_o) begin
            next_w_have = 1'b1;
            next_wdata = s_wdata_i;
            next_wstrb = s_wstrb_i;
        end
        if (wr_o) begin
            next_aw_have = 1'b0;
            next_w_have = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_err_i ? RESP_SLVERR : RESP_OKAY;
        end else if (bvalid && s_bready_i) begin
            next_bvalid = 1'b0;
        end
        if (rd_o) begin
            next_rvalid = 1'b1;
            next_rdata = rd_data_i;
            next_rresp = rd_err_i ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid && s_rready_i) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            awaddr <= '0;
            wdata <= 32'h0000_0000;
            wstrb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= 32'h0000_0000;
        end else begin
            aw_have <= next_aw_have;
            w_have <= next_w_have;
            awaddr <= next_awaddr;
            wdata <= next_wdata;
            wstrb <= next_wstrb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end
endmodule // csf_axil

// File: hw/csf_pkg.sv
// Package: register map, field positions and reset values of the status flag block
package csf_pkg;
    localparam int unsigned AW = 8;
    localparam logic [7:0] OFS_STATUS = 8'h68;
    localparam logic [7:0] OFS_SET = 8'h4C;
    localparam logic [7:0] OFS_RESET = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h70;
    localparam logic [7:0] OFS_CTRL = 8'h74;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h78;
    localparam logic [7:0] OFS_PASSIVE = 8'h7C;
    localparam logic [7:0] OFS_HALL = 8'h80;
    localparam int unsigned BIT_T2CM = 8;
    localparam int unsigned BIT_T2PM = 9;
    localparam int unsigned BIT_TRAP_FLAG = 10;
    localparam int unsigned BIT_TRAP_STATE = 11;
    localparam int unsigned BIT_HALL_OK = 12;
    localparam int unsigned BIT_HALL_WRONG = 13;
    localparam int unsigned BIT_IDLE = 14;
    localparam int unsigned BIT_SHADOW_DONE = 15;
    localparam int unsigned CTRL_TRPEN = 0;
    localparam int unsigned CTRL_TRPM = 1;
    localparam int unsigned CTRL_MCMEN = 2;
    localparam int unsigned CTRL_TRPSYNC = 3;
    localparam int unsigned NFLAG = 8;
    localparam int unsigned NOUT = 6;
    localparam int unsigned NHALL = 3;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// File: hw/csf_sync2.sv
// Two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module csf_sync2 #(
    parameter int unsigned W = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] stage1;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule // csf_sync2

// File: hw/csf_top.sv
// Upper status flags of the capture/compare unit: trap, hall, timer2 and shadow events
// Functional notes
// - Timer2 compare match sets sticky bit 8 until reset.
// - Timer2 period match sets sticky bit 9 until reset.
// - Trap flag bit 10 set when trap enabled and trap input low, or by software.
// - Release mode 0 with trap enabled: flag clears when trap input goes inactive.
// - Release mode 1: trap flag cleared only by software.
// - While trap state bit 11 set, selected outputs take passive level.
// - Trap state held while flag set; clears on sync after flag clears.
// - Valid hall edge with inputs equal expected pattern sets bit 12.
// - Valid hall edge matching neither current nor expected sets bit 13.
// - Idle bit 14 set with wrong hall event; only software clears it.
// - While idle set, pattern field held at zero, selected outputs passive.
// - Shadow copy into active pattern in multichannel mode sets bit 15.
// - Writing one to set register sets matching flag (not trap state bit 11) and raises interrupt.
// - Set register reads as zero.
// - Writing one to reset register clears the flag (not trap state bit 11); zero does nothing.
// - Every set condition raises an interrupt event, even if flag already set.
// - Software setting trap flag also sets trap state.
`timescale 1ns/1ps
module csf_top (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [csf_pkg::AW-1:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    input wire logic [csf_pkg::AW-1:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    input wire logic timer2_compare_match_i,
    input wire logic timer2_period_match_i,
    input wire logic trap_input_i,
    input wire logic [csf_pkg::NHALL-1:0] hall_position_inputs_i,
    input wire logic hall_edge_i,
    input wire logic trap_sync_i,
    input wire logic shadow_transfer_i,
    input wire logic [csf_pkg::NOUT-1:0] multichannel_shadow_pattern_i,
    input wire logic [csf_pkg::NOUT-1:0] pwm_outputs_i,
    output logic [csf_pkg::NOUT-1:0] multichannel_pattern_o,
    output logic [csf_pkg::NOUT-1:0] ccu_outputs_o,
    output logic irq_o
);
    import csf_pkg::*;

    logic wr, rd, wr_err, rd_err;
    logic [AW-1:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;
    logic trap_in_s;
    logic [NHALL-1:0] hall_s;

    csf_axil u_axil (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .s_awaddr_i(s_awaddr_i),
        .s_awvalid_i(s_awvalid_i),
        .s_awready_o(s_awready_o),
        .s_wdata_i(s_wdata_i),
        .s_wstrb_i(s_wstrb_i),
        .s_wvalid_i(s_wvalid_i),
        .s_wready_o(s_wready_o),
        .s_bresp_o(s_bresp_o),
        .s_bvalid_o(s_bvalid_o),
        .s_bready_i(s_bready_i),
        .s_araddr_i(s_araddr_i),
        .s_arvalid_i(s_arvalid_i),
        .s_arready_o(s_arready_o),
        .s_rdata_o(s_rdata_o),
        .s_rresp_o(s_rresp_o),
        .s_rvalid_o(s_rvalid_o),
        .s_rready_i(s_rready_i),
        .wr_o(wr),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .wr_strb_o(wr_strb),
        .wr_err_i(wr_err),
        .rd_o(rd),
        .rd_addr_o(rd_addr),
        .rd_data_i(rd_data),
        .rd_err_i(rd_err)
    );

    // Trap pin and hall sensors are asynchronous pins
    csf_sync2 #(.W(1 + NHALL)) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .async_i({trap_input_i, hall_position_inputs_i}),
        .sync_o({trap_in_s, hall_s})
    );

    // Register state
    logic [NFLAG-1:0] flags, next_flags;
    logic [NFLAG-1:0] irq_stat, next_irq_stat;
    logic [NFLAG-1:0] mask, next_mask;
    logic [3:0] ctrl, next_ctrl;
    logic [NOUT-1:0] passive_level_config, next_passive;
    logic [NOUT-1:0] passive_sel, next_passive_sel;
    logic [NHALL-1:0] current_hall_pattern, next_current_hall_pattern;
    logic [NHALL-1:0] expected_hall_pattern, next_expected_hall_pattern;
    logic [NOUT-1:0] mcm_pat, next_mcm_pat;
    logic [NOUT-1:0] ccu_out, next_ccu_out;

    logic trap_pin_enable, trap_release_mode, mcm_enable, trap_sync_mode;
    assign trap_pin_enable = ctrl[CTRL_TRPEN];
    assign trap_release_mode = ctrl[CTRL_TRPM];
    assign mcm_enable = ctrl[CTRL_MCMEN];
    assign trap_sync_mode = ctrl[CTRL_TRPSYNC];

    logic w_set, w_rst, w_lo, w_hi;
    assign w_lo = wr && wr_strb[0];
    assign w_hi = wr && wr_strb[1];
    assign w_set = w_hi && wr_addr == OFS_SET;
    assign w_rst = w_hi && wr_addr == OFS_RESET;

    logic [NFLAG-1:0] sw_set, sw_clr, hw_set, set_ev, clr_ev;
    logic hall_match, hall_wrong, trap_active;

    always_comb begin
        trap_active = trap_pin_enable && !trap_in_s;
        hall_match = hall_s == expected_hall_pattern;
        hall_wrong = hall_s != current_hall_pattern && !hall_match;
        sw_set = w_set ? wr_data[15:8] : '0;
        sw_clr = w_rst ? wr_data[15:8] : '0;
        // Bit 11 of the set register is ignored; software cannot set trap state directly
        sw_set[BIT_TRAP_STATE-8] = 1'b0;
        hw_set = '0;
        hw_set[BIT_T2CM-8] = timer2_compare_match_i;
        hw_set[BIT_T2PM-8] = timer2_period_match_i;
        hw_set[BIT_TRAP_FLAG-8] = trap_active;
        hw_set[BIT_HALL_OK-8] = hall_edge_i && hall_match;
        hw_set[BIT_HALL_WRONG-8] = hall_edge_i && hall_wrong;
        hw_set[BIT_IDLE-8] = hall_edge_i && hall_wrong;
        hw_set[BIT_SHADOW_DONE-8] = shadow_transfer_i && mcm_enable;
        set_ev = sw_set | hw_set;
        // Software trap set also enters trap state
        set_ev[BIT_TRAP_STATE-8] = set_ev[BIT_TRAP_FLAG-8] || sw_set[BIT_TRAP_FLAG-8];
        clr_ev = sw_clr;
        clr_ev[BIT_TRAP_STATE-8] = 1'b0;
        // Release mode 0: flag follows the pin going inactive
        if (!trap_release_mode && trap_pin_enable && trap_in_s) begin
            clr_ev[BIT_TRAP_FLAG-8] = clr_ev[BIT_TRAP_FLAG-8] || !sw_set[BIT_TRAP_FLAG-8];
        end
        // Release mode 1 leaves only the software clear in clr_ev
        // State leaves only once the flag is gone and the selected sync point is seen
        if (!flags[BIT_TRAP_FLAG-8] && (!trap_sync_mode || trap_sync_i)) begin
            clr_ev[BIT_TRAP_STATE-8] = 1'b1;
        end
        // Set wins over clear on every flag
        next_flags = (flags & ~clr_ev) | set_ev;
        // Status is cleared by read; the new event in the same cycle survives
        next_irq_stat = irq_stat | set_ev;
        if (rd && rd_addr == OFS_IRQ_STAT) begin
            next_irq_stat = set_ev;
        end
        next_mask = mask;
        next_ctrl = ctrl;
        next_passive = passive_level_config;
        next_passive_sel = passive_sel;
        next_expected_hall_pattern = expected_hall_pattern;
        next_current_hall_pattern = current_hall_pattern;
        if (w_lo && wr_addr == OFS_MASK) begin
            next_mask = wr_data[NFLAG-1:0];
        end
        if (w_lo && wr_addr == OFS_CTRL) begin
            next_ctrl = wr_data[3:0];
        end
        if (w_lo && wr_addr == OFS_PASSIVE) begin
            next_passive = wr_data[NOUT-1:0];
        end
        if (w_hi && wr_addr == OFS_PASSIVE) begin
            next_passive_sel = wr_data[8+NOUT-1:8];
        end
        if (w_lo && wr_addr == OFS_HALL) begin
            next_current_hall_pattern = wr_data[NHALL-1:0];
            next_expected_hall_pattern = wr_data[4+NHALL-1:4];
        end
        if (hall_edge_i && hall_match) begin
            next_current_hall_pattern = expected_hall_pattern;
        end
        next_mcm_pat = mcm_pat;
        if (shadow_transfer_i && mcm_enable) begin
            next_mcm_pat = multichannel_shadow_pattern_i;
        end
        if (next_flags[BIT_IDLE-8]) begin
            next_mcm_pat = '0;
        end
        for (int i = 0; i < NOUT; i++) begin
            if (passive_sel[i] && (flags[BIT_TRAP_STATE-8] || flags[BIT_IDLE-8])) begin
                next_ccu_out[i] = passive_level_config[i];
            end else begin
                next_ccu_out[i] = pwm_outputs_i[i] & (mcm_enable ? mcm_pat[i] : 1'b1);
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            flags <= FLAGS_RST;
            irq_stat <= FLAGS_RST;
            mask <= FLAGS_RST;
            ctrl <= CTRL_RST[3:0];
            passive_level_config <= '0;
            passive_sel <= '0;
            current_hall_pattern <= '0;
            expected_hall_pattern <= '0;
            mcm_pat <= '0;
            ccu_out <= '0;
        end else begin
            flags <= next_flags;
            irq_stat <= next_irq_stat;
            mask <= next_mask;
            ctrl <= next_ctrl;
            passive_level_config <= next_passive;
            passive_sel <= next_passive_sel;
            current_hall_pattern <= next_current_hall_pattern;
            expected_hall_pattern <= next_expected_hall_pattern;
            mcm_pat <= next_mcm_pat;
            ccu_out <= next_ccu_out;
        end
    end

    assign irq_o = |(irq_stat & mask);
    assign multichannel_pattern_o = mcm_pat;
    assign ccu_outputs_o = ccu_out;

    // Read mux; the set and reset registers read back zero
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        unique case (rd_addr)
            OFS_STATUS: rd_data = {16'h0000, flags, 8'h00};
            OFS_SET: rd_data = 32'h0000_0000;
            OFS_RESET: rd_data = 32'h0000_0000;
            OFS_MASK: rd_data = {24'h00_0000, mask};
            OFS_CTRL: rd_data = {28'h000_0000, ctrl};
            OFS_IRQ_STAT: rd_data = {24'h00_0000, irq_stat};
            OFS_PASSIVE: rd_data = {18'h0_0000, passive_sel, 2'b00, passive_level_config};
            OFS_HALL: rd_data = {25'h000_0000, expected_hall_pattern, 1'b0,
                                 current_hall_pattern};
            default: rd_err = 1'b1;
        endcase
        wr_err = !(wr_addr inside {OFS_STATUS, OFS_SET, OFS_RESET, OFS_MASK, OFS_CTRL,
                                   OFS_IRQ_STAT, OFS_PASSIVE, OFS_HALL});
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    t2cm_sticky_a: assert property (timer2_compare_match_i |=> flags[0])
        else $error("compare match flag not set");
    t2pm_sticky_a: assert property (flags[1] && !sw_clr[1] |=> flags[1])
        else $error("period match flag lost");
    trap_set_a: assert property (trap_active |=> flags[2] && flags[3])
        else $error("trap flag not set on pin");
    trap_auto_a: assert property (!trap_release_mode && trap_pin_enable && trap_in_s
        && !sw_set[2] |=> !flags[2])
        else $error("trap flag not auto cleared");
    trap_hold_a: assert property (trap_release_mode && flags[2] && !sw_clr[2]
        |=> flags[2])
        else $error("trap flag cleared by hardware");
    passive_out_a: assert property (flags[3] && passive_sel[0]
        |=> ccu_outputs_o[0] == $past(passive_level_config[0]))
        else $error("output not passive in trap");
    state_hold_a: assert property (flags[2] |-> flags[3])
        else $error("trap state clear while flag set");
    idle_pat_a: assert property (flags[6] |-> multichannel_pattern_o == '0)
        else $error("pattern not held at zero in idle");
    whe_idle_a: assert property (hall_edge_i && hall_wrong |=> flags[5] && flags[6])
        else $error("wrong hall did not set idle");
    che_set_a: assert property (hall_edge_i && hall_match |=> flags[4])
        else $error("correct hall not flagged");
    str_set_a: assert property (shadow_transfer_i && mcm_enable |=> flags[7])
        else $error("shadow transfer not flagged");
    swset_irq_a: assert property (sw_set[0] && mask[0] |=> irq_o)
        else $error("software set gave no interrupt");
    sw_clr_a: assert property (sw_clr[1] && !hw_set[1] |=> !flags[1])
        else $error("reset register did not clear");
    set_read_a: assert property (rd && rd_addr == OFS_SET |-> rd_data == '0)
        else $error("set register read nonzero");
    swtrap_a: assert property (sw_set[2] |=> flags[3])
        else $error("software trap missed state");
    trap_cv: cover property (trap_active ##1 flags[3]);
    whe_cv: cover property (hall_edge_i && hall_wrong);
    irq_cv: cover property (irq_o);
endmodule // csf_top
